// File: core/cpu_regs_consts.svh
// Register indices, flag bit positions, reset values for the core register set.
// Assumes inclusion by bare name from the register file and its package users.
`ifndef CPU_REGS_CONSTS_SVH
`define CPU_REGS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register port addresses (word index; pair addresses span two registers)
// ----------------------------------------------------------------------------
`define ADDR_DATA_ZERO       5'h00
`define ADDR_DATA_ONE        5'h01
`define ADDR_DATA_TWO        5'h02
`define ADDR_DATA_THREE      5'h03
`define ADDR_ADDR_ZERO       5'h04
`define ADDR_ADDR_ONE        5'h05
`define ADDR_FRAME_BASE      5'h06
`define ADDR_VECTOR_BASE     5'h07
`define ADDR_NEXT_INSTR      5'h08
`define ADDR_USER_SP         5'h09
`define ADDR_INTR_SP         5'h0A
`define ADDR_STATIC_BASE     5'h0B
`define ADDR_FLAG_WORD       5'h0C
`define ADDR_ACTIVE_SP       5'h0D
`define ADDR_DATA_PAIR_LOW   5'h0E
`define ADDR_DATA_PAIR_HIGH  5'h0F
`define ADDR_ADDR_PAIR       5'h10
`define ADDR_DATA_ZERO_LO    5'h11
`define ADDR_DATA_ZERO_HI    5'h12
`define ADDR_DATA_ONE_LO     5'h13
`define ADDR_DATA_ONE_HI     5'h14

// ----------------------------------------------------------------------------
// Banked set and flag word layout
// ----------------------------------------------------------------------------
`define BANK_ENTRIES         7
`define BANK_COUNT           2
`define FLAG_WIDTH           11
`define FLAG_C               0
`define FLAG_D               1
`define FLAG_Z               2
`define FLAG_S               3
`define FLAG_B               4
`define FLAG_O               5
`define FLAG_I               6
`define FLAG_U               7
`define FLAG_IPL_LSB         8
`define FLAG_IPL_MSB         10
`define FLAG_RESET           11'h000
`define SWI_STACK_CLEAR_MAX  6'h1F

`endif

// File: core/cpu_regs_pkg.sv
// Types shared by the core register set and the execution logic beside it.
// Widths and codes here are written out, not taken from the constants header.
package cpu_regs_pkg;

   // Operand size of the ALU result that sets the condition flags
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'b00,
      SIZE_WORD = 2'b01,
      SIZE_LONG = 2'b10
   } alu_size_type;

   // Condition update from the ALU, one cycle per operation
   typedef struct packed {
      logic         valid;
      alu_size_type size;
      logic [31:0]  result;
      logic         carry;
      logic         overflow;
      logic         upd_carry;
      logic         upd_zero;
      logic         upd_sign;
      logic         upd_overflow;
   } alu_update_type;

   // Program counter step or jump
   typedef struct packed {
      logic        load;
      logic [19:0] target;
      logic [3:0]  advance;
   } pc_update_type;

   // Interrupt acknowledge and software interrupt events
   typedef struct packed {
      logic       hw_ack;
      logic       sw_exec;
      logic [5:0] sw_number;
      logic       load_level;
      logic [2:0] new_level;
   } int_event_type;

   // Pending maskable request offered for acceptance
   typedef struct packed {
      logic       valid;
      logic [2:0] level;
   } irq_request_type;

endpackage : cpu_regs_pkg

// File: core/cpu_register_file_flags.sv
// Processor state registers: two banks of data/address/frame-base registers,
// program counter, vector table base, stack pointers, static base, flag word.
// Assumes execution logic on the same clock drives the register port and
// the ALU, program counter and interrupt event inputs.
//
// Function
// [RULE1] Thirteen registers, seven of them banked twice
// [RULE2] Data registers 16 bits, first two byte-split
// [RULE3] Data pairs form two 32-bit registers
// [RULE4] Address registers pair, second is upper half
// [RULE5] Frame base is 16 bits, frame addressing base
// [RULE6] Static base is 16 bits, static addressing base
// [RULE7] Vector table base holds 20-bit table address
// [RULE8] Program counter holds 20-bit next instruction address
// [RULE9] Stack flag picks interrupt or user pointer
// [RULE10] Hardware ack or low software interrupt clears stack flag
// [RULE11] Flag word is 11 bits of state
// [RULE12] Carry flag captures ALU carry or shift-out
// [RULE13] Software keeps debug flag at zero
// [RULE14] Zero flag tracks zero result
// [RULE15] Sign flag tracks negative result
// [RULE16] Bank flag selects register bank
// [RULE17] Overflow flag tracks overflow
// [RULE18] Interrupt enable gates, cleared on acknowledge
// [RULE19] Request accepted only above priority level
// [RULE20] Reserved flag bit written zero, reads undefined
// [RULE21] Reset clears flags, bank zero, interrupt stack
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "cpu_regs_consts.svh"

module cpu_register_file_flags (
   input  wire logic                         i_clk,       // Core clock, 100 MHz
   input  wire logic                         i_rst,       // Synchronous reset, high
   input  wire logic                         i_ce,        // Clock enable, freezes state
   input  wire logic [4:0]                   i_addr,      // Register address
   input  wire logic [31:0]                  i_wdata,     // Write data
   input  wire logic                         i_wr,        // Write strobe
   input  wire logic                         i_rd,        // Read strobe
   input  wire cpu_regs_pkg::alu_update_type  i_alu,       // ALU condition update
   input  wire cpu_regs_pkg::pc_update_type   i_pc,        // Program counter update
   input  wire cpu_regs_pkg::int_event_type   i_int,       // Interrupt events
   input  wire cpu_regs_pkg::irq_request_type i_irq,       // Pending maskable request
   output logic [31:0]                        o_rdata,     // Read data, cycle after read
   output logic [10:0]                        o_flags,     // Flag word
   output logic [19:0]                        o_pc,        // Next instruction address
   output logic [19:0]                        o_vector_base, // Vector table base
   output logic [15:0]                        o_frame_base,  // Active bank frame base
   output logic [15:0]                        o_static_base, // Static base
   output logic [15:0]                        o_active_sp,   // Selected stack pointer
   output logic                               o_irq_accept   // Request accepted
);

   // ----------------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------------
   logic [`FLAG_WIDTH-1:0]  flags_ff;
   logic [`FLAG_WIDTH-1:0]  nxt_flags;
   logic [19:0]             pc_ff;
   logic [19:0]             vector_base_ff;
   logic [15:0]             usp_ff;
   logic [15:0]             isp_ff;
   logic [15:0]             static_base_ff;
   logic [15:0]             frame_base_ff;
   logic [15:0]             active_sp_ff;
   logic [31:0]             rdata_ff;
   logic                    irq_accept_ff;
   logic [31:0]             read_value;
   logic                    res_zero;
   logic                    res_sign;
   logic                    bank_sel;
   logic [`BANK_ENTRIES-1:0][15:0] bank_view [0:`BANK_COUNT-1];
   logic [`BANK_ENTRIES-1:0][15:0] cur_bank;

   assign bank_sel = flags_ff[`FLAG_B];                     // RULE16
   assign cur_bank = bank_view[bank_sel];

   // ----------------------------------------------------------------------------
   // Banked registers, one copy per bank
   // ----------------------------------------------------------------------------
   // Only the bank picked by the flag word takes writes; the other holds.
   generate
      for (genvar gb = 0; gb < `BANK_COUNT; gb++)
      begin : g_bank
         logic [`BANK_ENTRIES-1:0][15:0] regs_ff;
         always_ff @(posedge i_clk)
         begin
            if (i_rst)
            begin
               regs_ff <= '0;
            end
            else if (i_ce && i_wr && (bank_sel == 1'(gb)))  // RULE1
            begin
               case (i_addr)
                  `ADDR_DATA_PAIR_LOW:                        // RULE3
                  begin
                     regs_ff[0] <= i_wdata[15:0];
                     regs_ff[2] <= i_wdata[31:16];
                  end
                  `ADDR_DATA_PAIR_HIGH:                       // RULE3
                  begin
                     regs_ff[1] <= i_wdata[15:0];
                     regs_ff[3] <= i_wdata[31:16];
                  end
                  `ADDR_ADDR_PAIR:                            // RULE4
                  begin
                     regs_ff[4] <= i_wdata[15:0];
                     regs_ff[5] <= i_wdata[31:16];
                  end
                  `ADDR_DATA_ZERO_LO: regs_ff[0][7:0]  <= i_wdata[7:0];   // RULE2
                  `ADDR_DATA_ZERO_HI: regs_ff[0][15:8] <= i_wdata[7:0];   // RULE2
                  `ADDR_DATA_ONE_LO:  regs_ff[1][7:0]  <= i_wdata[7:0];   // RULE2
                  `ADDR_DATA_ONE_HI:  regs_ff[1][15:8] <= i_wdata[7:0];   // RULE2
                  default:
                  begin
                     // Plain 16-bit views share their index with their address
                     if (i_addr < 5'(`BANK_ENTRIES))
                        regs_ff[i_addr[2:0]] <= i_wdata[15:0];          // RULE5
                  end
               endcase
            end
         end
         assign bank_view[gb] = regs_ff;
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // ALU result classification
   // ----------------------------------------------------------------------------
   // Zero and sign follow the operand size, not the full 32-bit bus
   always_comb
   begin
      case (i_alu.size)
         cpu_regs_pkg::SIZE_BYTE:
         begin
            res_zero = (i_alu.result[7:0] == 8'h00);
            res_sign = i_alu.result[7];
         end
         cpu_regs_pkg::SIZE_LONG:
         begin
            res_zero = (i_alu.result == 32'h0000_0000);
            res_sign = i_alu.result[31];
         end
         default:
         begin
            res_zero = (i_alu.result[15:0] == 16'h0000);
            res_sign = i_alu.result[15];
         end
      endcase
   end

   // ----------------------------------------------------------------------------
   // Flag word next value
   // ----------------------------------------------------------------------------
   // Priority: register write, then ALU, then interrupt events. Hardware
   // events are applied last so a racing software write cannot undo them.
   always_comb
   begin
      nxt_flags = flags_ff;
      if (i_wr && (i_addr == `ADDR_FLAG_WORD))
         nxt_flags = i_wdata[`FLAG_WIDTH-1:0];              // RULE11 RULE20
      if (i_alu.valid)
      begin
         if (i_alu.upd_carry)
            nxt_flags[`FLAG_C] = i_alu.carry;               // RULE12
         if (i_alu.upd_zero)
            nxt_flags[`FLAG_Z] = res_zero;                  // RULE14
         if (i_alu.upd_sign)
            nxt_flags[`FLAG_S] = res_sign;                  // RULE15
         if (i_alu.upd_overflow)
            nxt_flags[`FLAG_O] = i_alu.overflow;            // RULE17
      end
      if (i_int.hw_ack || i_int.sw_exec)
         nxt_flags[`FLAG_I] = 1'b0;                         // RULE18
      if (i_int.hw_ack || (i_int.sw_exec && (i_int.sw_number <= `SWI_STACK_CLEAR_MAX)))
         nxt_flags[`FLAG_U] = 1'b0;                         // RULE10
      if (i_int.load_level)
         nxt_flags[`FLAG_IPL_MSB:`FLAG_IPL_LSB] = i_int.new_level;
   end

   // Flag word register; reset ignores the clock enable
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         flags_ff <= `FLAG_RESET;                           // RULE21
      else if (i_ce)
         flags_ff <= nxt_flags;
   end

   // ----------------------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------------------
   // Core jumps and steps take precedence over a register-port write
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         pc_ff <= 20'h00000;
      else if (i_ce)
      begin
         if (i_pc.load)
            pc_ff <= i_pc.target;                           // RULE8
         else if (i_pc.advance != 4'h0)
            pc_ff <= pc_ff + 20'(i_pc.advance);             // RULE8
         else if (i_wr && (i_addr == `ADDR_NEXT_INSTR))
            pc_ff <= i_wdata[19:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Unbanked base registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         vector_base_ff <= 20'h00000;
         static_base_ff <= 16'h0000;
      end
      else if (i_ce && i_wr)
      begin
         if (i_addr == `ADDR_VECTOR_BASE)
            vector_base_ff <= i_wdata[19:0];                // RULE7
         if (i_addr == `ADDR_STATIC_BASE)
            static_base_ff <= i_wdata[15:0];                // RULE6
      end
   end

   // ----------------------------------------------------------------------------
   // Stack pointers
   // ----------------------------------------------------------------------------
   // The active-pointer address lands in whichever pointer the flag selects
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         usp_ff <= 16'h0000;
         isp_ff <= 16'h0000;
      end
      else if (i_ce && i_wr)
      begin
         if ((i_addr == `ADDR_USER_SP) ||
             ((i_addr == `ADDR_ACTIVE_SP) && flags_ff[`FLAG_U]))
            usp_ff <= i_wdata[15:0];                        // RULE9
         if ((i_addr == `ADDR_INTR_SP) ||
             ((i_addr == `ADDR_ACTIVE_SP) && !flags_ff[`FLAG_U]))
            isp_ff <= i_wdata[15:0];                        // RULE9
      end
   end

   // Registered views: one cycle behind, so outputs come from flops
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         active_sp_ff  <= 16'h0000;
         frame_base_ff <= 16'h0000;
      end
      else if (i_ce)
      begin
         active_sp_ff  <= flags_ff[`FLAG_U] ? usp_ff : isp_ff;   // RULE9
         frame_base_ff <= cur_bank[6];                           // RULE5
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupt acceptance
   // ----------------------------------------------------------------------------
   // Strictly greater than the level, so level 7 masks every request
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         irq_accept_ff <= 1'b0;
      else if (i_ce)
         irq_accept_ff <= i_irq.valid && flags_ff[`FLAG_I] &&
                          (i_irq.level > flags_ff[`FLAG_IPL_MSB:`FLAG_IPL_LSB]); // RULE19
   end

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------
   // Unmapped addresses read as zero; the flag word reads back all 11 bits as stored
   always_comb
   begin
      case (i_addr)
         `ADDR_VECTOR_BASE:    read_value = {12'h000, vector_base_ff};
         `ADDR_NEXT_INSTR:     read_value = {12'h000, pc_ff};
         `ADDR_USER_SP:        read_value = {16'h0000, usp_ff};
         `ADDR_INTR_SP:        read_value = {16'h0000, isp_ff};
         `ADDR_STATIC_BASE:    read_value = {16'h0000, static_base_ff};
         `ADDR_FLAG_WORD:      read_value = {21'h000000, flags_ff};     // RULE20
         `ADDR_ACTIVE_SP:      read_value = {16'h0000, flags_ff[`FLAG_U] ? usp_ff : isp_ff};
         `ADDR_DATA_PAIR_LOW:  read_value = {cur_bank[2], cur_bank[0]}; // RULE3
         `ADDR_DATA_PAIR_HIGH: read_value = {cur_bank[3], cur_bank[1]}; // RULE3
         `ADDR_ADDR_PAIR:      read_value = {cur_bank[5], cur_bank[4]}; // RULE4
         `ADDR_DATA_ZERO_LO:   read_value = {24'h000000, cur_bank[0][7:0]};
         `ADDR_DATA_ZERO_HI:   read_value = {24'h000000, cur_bank[0][15:8]};
         `ADDR_DATA_ONE_LO:    read_value = {24'h000000, cur_bank[1][7:0]};
         `ADDR_DATA_ONE_HI:    read_value = {24'h000000, cur_bank[1][15:8]};
         default:
         begin
            if (i_addr < 5'(`BANK_ENTRIES))
               read_value = {16'h0000, cur_bank[i_addr[2:0]]};
            else
               read_value = 32'h0000_0000;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         rdata_ff <= 32'h0000_0000;
      else if (i_ce)
         rdata_ff <= i_rd ? read_value : 32'h0000_0000;
   end

   assign o_rdata       = rdata_ff;
   assign o_flags       = flags_ff;
   assign o_pc          = pc_ff;
   assign o_vector_base = vector_base_ff;
   assign o_frame_base  = frame_base_ff;
   assign o_static_base = static_base_ff;
   assign o_active_sp   = active_sp_ff;
   assign o_irq_accept  = irq_accept_ff;

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_flag_read;
      i_ce && i_rd && (i_addr == `ADDR_FLAG_WORD) |=> o_rdata == {21'h000000, $past(flags_ff)};
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag read mismatch"); // RULE11

   property p_flag_write;
      i_ce && i_wr && (i_addr == `ADDR_FLAG_WORD) && !i_alu.valid && !i_int.hw_ack &&
      !i_int.sw_exec && !i_int.load_level |=> flags_ff == $past(i_wdata[10:0]);
   endproperty
   a_flag_write: assert property (p_flag_write) else $error("flag write lost"); // RULE20

   property p_hw_ack;
      i_ce && i_int.hw_ack |=> !flags_ff[`FLAG_U] && !flags_ff[`FLAG_I] ##1
                               (!$past(i_ce) || o_active_sp == $past(isp_ff));
   endproperty
   a_hw_ack: assert property (p_hw_ack) else $error("ack did not select stack"); // RULE10

   property p_swi_high;
      i_ce && i_int.sw_exec && (i_int.sw_number > `SWI_STACK_CLEAR_MAX) && !i_int.hw_ack &&
      !(i_wr && (i_addr == `ADDR_FLAG_WORD)) |=> flags_ff[`FLAG_U] == $past(flags_ff[`FLAG_U]);
   endproperty
   a_swi_high: assert property (p_swi_high) else $error("high swi changed stack"); // RULE10

   property p_ack_ie;
      i_ce && (i_int.hw_ack || i_int.sw_exec) |=> !flags_ff[`FLAG_I];
   endproperty
   a_ack_ie: assert property (p_ack_ie) else $error("enable not cleared"); // RULE18

   property p_zero;
      i_ce && i_alu.valid && i_alu.upd_zero && (i_alu.size == cpu_regs_pkg::SIZE_WORD)
      |=> flags_ff[`FLAG_Z] == ($past(i_alu.result[15:0]) == 16'h0000);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE14

   property p_sign;
      i_ce && i_alu.valid && i_alu.upd_sign && (i_alu.size == cpu_regs_pkg::SIZE_BYTE)
      |=> flags_ff[`FLAG_S] == $past(i_alu.result[7]);
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag wrong"); // RULE15

   property p_carry_ovf;
      i_ce && i_alu.valid && i_alu.upd_carry && i_alu.upd_overflow
      |=> flags_ff[`FLAG_C] == $past(i_alu.carry) && flags_ff[`FLAG_O] == $past(i_alu.overflow);
   endproperty
   a_carry_ovf: assert property (p_carry_ovf) else $error("carry or ovf wrong"); // RULE12 RULE17

   property p_bank_write;
      i_ce && i_wr && (i_addr == `ADDR_DATA_PAIR_LOW)
      |=> {bank_view[$past(bank_sel)][2], bank_view[$past(bank_sel)][0]} == $past(i_wdata);
   endproperty
   a_bank_write: assert property (p_bank_write) else $error("wide write bank"); // RULE16 RULE3

   property p_pc_step;
      i_ce && !i_pc.load && (|i_pc.advance) |=> o_pc == $past(o_pc) + 20'($past(i_pc.advance));
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc step wrong"); // RULE8

   property p_irq;
      i_ce |=> o_irq_accept == ($past(i_irq.valid) && $past(flags_ff[`FLAG_I]) &&
               ($past(i_irq.level) > $past(flags_ff[`FLAG_IPL_MSB:`FLAG_IPL_LSB])));
   endproperty
   a_irq: assert property (p_irq) else $error("accept gate wrong"); // RULE19

   property p_reset;
      $past(i_rst) && !i_rst |-> flags_ff == `FLAG_RESET && o_active_sp == 16'h0000;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong"); // RULE21

   c_hw_ack:  cover property (i_ce && i_int.hw_ack && flags_ff[`FLAG_U]);
   c_accept:  cover property (o_irq_accept);
   c_bank1:   cover property (i_ce && i_wr && bank_sel);
   c_swi_low: cover property (i_ce && i_int.sw_exec && (i_int.sw_number <= `SWI_STACK_CLEAR_MAX));

endmodule : cpu_register_file_flags

// File: dv/exec_side_model.sv
// Execution-side model: drives ALU, PC and interrupt inputs as one-cycle
// pulses. Assumes the bench calls its tasks and shares the core clock.
`timescale 1ns/1ps

module exec_side_model (
   input  wire logic                     i_clk, // Core clock
   output cpu_regs_pkg::alu_update_type  o_alu, // ALU flag update
   output cpu_regs_pkg::pc_update_type   o_pc,  // PC step
   output cpu_regs_pkg::int_event_type   o_int, // Interrupt events
   output cpu_regs_pkg::irq_request_type o_irq  // Pending request
);
   // --------------------
   // Pulse drivers
   // --------------------
   // Idle at time zero so no input floats
   initial
   begin
      o_alu = '0;
      o_pc  = '0;
      o_int = '0;
      o_irq = '0;
   end

   // All four flag updates selected, so carry, zero, sign and overflow must all follow
   task automatic alu_op(input cpu_regs_pkg::alu_size_type sz, input logic [31:0] r,
                         input logic c, input logic ov);
      @(posedge i_clk);
      o_alu <= '{1'b1, sz, r, c, ov, 1'b1, 1'b1, 1'b1, 1'b1};
      @(posedge i_clk);
      o_alu <= '0;
   endtask : alu_op

   task automatic pc_step(input logic [3:0] adv);
      @(posedge i_clk);
      o_pc <= '{1'b0, 20'h00000, adv};
      @(posedge i_clk);
      o_pc <= '0;
   endtask : pc_step

   // Jump: load takes precedence over any step or port write
   task automatic pc_load(input logic [19:0] t);
      @(posedge i_clk);
      o_pc <= '{1'b1, t, 4'h0};
      @(posedge i_clk);
      o_pc <= '0;
   endtask : pc_load

   task automatic int_ev(input logic hw, input logic sw, input logic [5:0] n);
      @(posedge i_clk);
      o_int <= '{hw, sw, n, 1'b0, 3'h0};
      @(posedge i_clk);
      o_int <= '0;
   endtask : int_ev

   // Priority level load, the event path that moves the level
   task automatic level_ld(input logic [2:0] lv);
      @(posedge i_clk);
      o_int <= '{1'b0, 1'b0, 6'h00, 1'b1, lv};
      @(posedge i_clk);
      o_int <= '0;
   endtask : level_ld

   // Request held one cycle only; acceptance is judged from that cycle
   task automatic irq_req(input logic [2:0] lvl);
      @(posedge i_clk);
      o_irq <= '{1'b1, lvl};
      @(posedge i_clk);
      o_irq <= '0;
   endtask : irq_req
endmodule : exec_side_model

// File: dv/tb_top.sv
// Bench for the register set: port accesses plus execution-side events.
// Assumes one 100 MHz clock and synchronous high reset.
`timescale 1ns/1ps

module tb_top;
   logic        i_clk;
   logic        i_rst;
   logic [4:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic        ce;
   logic [31:0] rdata;
   logic [10:0] flags;
   logic [19:0] pc;
   logic [19:0] vbase;
   logic [15:0] fbase;
   logic [15:0] sbase;
   logic [15:0] asp;
   logic        accept;
   int          bad_count;
   int          n_compared;
   cpu_regs_pkg::alu_update_type  alu;
   cpu_regs_pkg::pc_update_type   pcu;
   cpu_regs_pkg::int_event_type   inte;
   cpu_regs_pkg::irq_request_type irq;

   exec_side_model px (.i_clk(i_clk), .o_alu(alu), .o_pc(pcu), .o_int(inte), .o_irq(irq));

   cpu_register_file_flags dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_alu(alu), .i_pc(pcu), .i_int(inte),
      .i_irq(irq), .o_rdata(rdata), .o_flags(flags), .o_pc(pc), .o_vector_base(vbase),
      .o_frame_base(fbase), .o_static_base(sbase), .o_active_sp(asp),
      .o_irq_accept(accept));

   // --------------------
   // Access tasks
   // --------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Gap after each strobe so no strobe is driven twice in one step
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_chk

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   // Clock, watchdog at 2000 cycles, well beyond the roughly 100 cycles of the tests
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial
   begin
      #20000;
      bad_count++;
      complete_run();
   end

   // Flag writes keep the debug and reserved bits at 0
   initial
   begin
      {addr, wdata, wr, rd, bad_count, n_compared} = '0;
      ce    = 1'b1;
      i_rst = 1'b1;
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      #1 chk(32'(flags), 32'h0);
      wr_reg(5'h00, 32'h1234);
      wr_reg(5'h0C, 32'h010);
      wr_reg(5'h00, 32'hBEEF);
      rd_chk(5'h00, 32'hBEEF);
      wr_reg(5'h0C, 32'h000);
      rd_chk(5'h00, 32'h1234);
      wr_reg(5'h11, 32'hAB);
      wr_reg(5'h12, 32'hCD);
      rd_chk(5'h00, 32'hCDAB);
      wr_reg(5'h0E, 32'h89ABCDEF);
      rd_chk(5'h02, 32'h89AB);
      wr_reg(5'h0F, 32'h11223344);
      rd_chk(5'h03, 32'h1122);
      rd_chk(5'h14, 32'h33);
      wr_reg(5'h10, 32'h55667788);
      rd_chk(5'h05, 32'h5566);
      wr_reg(5'h06, 32'h0F0F);
      wr_reg(5'h0B, 32'h7A5A);
      chk(32'(fbase), 32'h0F0F);
      chk(32'(sbase), 32'h7A5A);
      wr_reg(5'h07, 32'hABCDE);
      chk(32'(vbase), 32'hABCDE);
      // A write while the clock enable is low must not land
      @(posedge i_clk) ce <= 1'b0;
      wr_reg(5'h0B, 32'h0001);
      chk(32'(sbase), 32'h7A5A);
      @(posedge i_clk) ce <= 1'b1;
      px.pc_step(4'h2);
      #1 chk(32'(pc), 32'h2);
      wr_reg(5'h08, 32'h12345);
      rd_chk(5'h08, 32'h12345);
      px.pc_load(20'hFEDCB);
      #1 chk(32'(pc), 32'hFEDCB);
      px.alu_op(cpu_regs_pkg::SIZE_BYTE, 32'h100, 1'b1, 1'b0);
      #1 chk(32'(flags), 32'h005);
      px.alu_op(cpu_regs_pkg::SIZE_WORD, 32'h8000, 1'b0, 1'b1);
      #1 chk(32'(flags), 32'h028);
      px.alu_op(cpu_regs_pkg::SIZE_LONG, 32'h80000000, 1'b0, 1'b0);
      #1 chk(32'(flags), 32'h008);
      wr_reg(5'h0C, 32'h0C0);
      wr_reg(5'h0D, 32'h1111);
      rd_chk(5'h09, 32'h1111);
      px.int_ev(1'b0, 1'b1, 6'h20);
      #1 chk(32'(flags), 32'h080);
      px.int_ev(1'b0, 1'b1, 6'h1F);
      #1 chk(32'(flags), 32'h000);
      @(posedge i_clk);
      #1 chk(32'(asp), 32'h0);
      wr_reg(5'h0C, 32'h0C0);
      px.int_ev(1'b1, 1'b0, 6'h00);
      #1 chk(32'(flags), 32'h000);
      wr_reg(5'h0A, 32'h2222);
      rd_chk(5'h0D, 32'h2222);
      wr_reg(5'h0C, 32'h240);
      rd_chk(5'h0C, 32'h240);
      px.irq_req(3'h3);
      #1 chk(32'(accept), 32'h1);
      px.irq_req(3'h2);
      #1 chk(32'(accept), 32'h0);
      px.level_ld(3'h5);
      #1 chk(32'(flags), 32'h540);
      rd_chk(5'h1F, 32'h0);
      complete_run();
   end
endmodule : tb_top
